// file: design/pmd_reg16.sv
`timescale 1ns/1ns
`default_nettype none
`include "pmd_defs.svh"

// one 16-bit disable register; only bits in the mask are stored
module pmd_reg16 #(
    parameter logic [15:0] MASK = 16'h0000
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic wrEn,
    input wire logic [15:0] wdata,
    output logic [15:0] value
);

    logic [15:0] value_q;
    logic [15:0] value_d;

    // masked write, unimplemented bits forced to zero
    always_comb begin
        value_d = value_q;
        if (wrEn) begin
            value_d = wdata & MASK;
        end
    end

    // cleared at power-on reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            value_q <= `PMD_RESET_VALUE;
        end else begin
            value_q <= value_d;
        end
    end

    assign value = value_q;

endmodule : pmd_reg16

`default_nettype wire

// file: design/pmd_regs.sv
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "pmd_defs.svh"

// Notes on behaviour
// [R1] bit 10 of comparator/i2c register set disables comparator, clear lets it run
// [R2] bit 3 of refclk register set disables reference clock output module
// [R3] unimplemented bits read zero and ignore writes
// [R4] implemented bits are read/write and clear to zero at reset
// [R5] pwm register bits 12..8 disable pwm generators 5..1; comparator/i2c register bit 1 disables i2c two
module pmd_regs (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [1:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    output logic comparator_off,
    output logic second_two_wire_off,
    output logic refclk_out_off,
    output logic [4:0] pwm_gen_off
);

    // ****************************************
    // request bundle and write decode
    // ****************************************
    pmd_pkg::pmd_req_t req;
    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    function automatic logic hit(input logic [1:0] a, input logic [1:0] idx);
        hit = (a == idx);
    endfunction : hit

    // write enables, one per register; index 3 has none
    logic wrCmpI2c;
    logic wrRefclk;
    logic wrPwm;
    assign wrCmpI2c = req.wr && hit(req.addr, `PMD_IDX_CMP_I2C);
    assign wrRefclk = req.wr && hit(req.addr, `PMD_IDX_REFCLK);
    assign wrPwm = req.wr && hit(req.addr, `PMD_IDX_PWM);

    pmd_pkg::pmd_word_t cmpI2cVal;
    pmd_pkg::pmd_word_t refclkVal;
    pmd_pkg::pmd_word_t pwmVal;

    // ****************************************
    // register storage
    // ****************************************
    // masked storage keeps unimplemented bits at zero (see [R3]), reset to zero (see [R4])
    pmd_reg16 #(.MASK(`PMD_MASK_CMP_I2C)) uCmpI2c (
        .clk(clk),
        .resetn(resetn),
        .wrEn(wrCmpI2c),
        .wdata(req.wdata),
        .value(cmpI2cVal)
    );

    pmd_reg16 #(.MASK(`PMD_MASK_REFCLK)) uRefclk (
        .clk(clk),
        .resetn(resetn),
        .wrEn(wrRefclk),
        .wdata(req.wdata),
        .value(refclkVal)
    );

    pmd_reg16 #(.MASK(`PMD_MASK_PWM)) uPwm (
        .clk(clk),
        .resetn(resetn),
        .wrEn(wrPwm),
        .wdata(req.wdata),
        .value(pwmVal)
    );

    // ****************************************
    // read path and disable outputs
    // ****************************************
    logic [15:0] rdata_d;
    logic [15:0] rdata_q;
    logic [7:0] off_d;
    logic [7:0] off_q;

    // read mux; unmapped index reads zero
    always_comb begin
        rdata_d = 16'h0000;
        if (req.rd) begin
            unique case (req.addr)
                `PMD_IDX_CMP_I2C: rdata_d = cmpI2cVal; // see [R4]
                `PMD_IDX_REFCLK: rdata_d = refclkVal;
                `PMD_IDX_PWM: rdata_d = pwmVal;
                default: rdata_d = 16'h0000;
            endcase
        end
    end

    // next disable levels follow the written value, one flop per disable bit
    always_comb begin
        off_d = {cmpI2cVal[`PMD_BIT_CMP], // see [R1]
                 cmpI2cVal[`PMD_BIT_I2C2],                     // see [R5]
                 refclkVal[`PMD_BIT_REFCLK],                   // see [R2]
                 pwmVal[`PMD_BIT_PWM_LO +: `PMD_PWM_COUNT]};   // see [R5]
    end

    // read data register, zero outside a read answer
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // disable output flops, every module enabled after reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            off_q <= 8'h00; // see [R4]
        end else begin
            off_q <= off_d;
        end
    end

    assign rdata = rdata_q;
    assign comparator_off = off_q[7];
    assign second_two_wire_off = off_q[6];
    assign refclk_out_off = off_q[5];
    assign pwm_gen_off = off_q[4:0];

    // ****************************************
    // assertions
    // ****************************************
    a_cmp_follows_write: assert property (@(posedge clk) disable iff (!resetn) // see [R1]
        wr && addr == `PMD_IDX_CMP_I2C |=> ##1 comparator_off == $past(wdata[`PMD_BIT_CMP], 2))
        else $error("comparator disable does not follow write");

    a_refclk_follows_write: assert property (@(posedge clk) disable iff (!resetn) // see [R2]
        wr && addr == `PMD_IDX_REFCLK |=> ##1 refclk_out_off == $past(wdata[`PMD_BIT_REFCLK], 2))
        else $error("refclk disable does not follow write");

    a_refclk_unimpl_zero: assert property (@(posedge clk) disable iff (!resetn) // see [R3]
        rd && addr == `PMD_IDX_REFCLK |=> (rdata & ~`PMD_MASK_REFCLK) == 16'h0000)
        else $error("unimplemented refclk bits read nonzero");

    a_cmp_unimpl_zero: assert property (@(posedge clk) disable iff (!resetn) // see [R3]
        rd && addr == `PMD_IDX_CMP_I2C |=> (rdata & ~`PMD_MASK_CMP_I2C) == 16'h0000)
        else $error("unimplemented comparator register bits read nonzero");

    a_pwm_readback: assert property (@(posedge clk) disable iff (!resetn) // see [R4]
        wr && addr == `PMD_IDX_PWM ##1 rd && addr == `PMD_IDX_PWM |=> rdata == ($past(wdata, 2) & `PMD_MASK_PWM))
        else $error("pwm register readback mismatch");

    a_pwm_gen_follows: assert property (@(posedge clk) disable iff (!resetn) // see [R5]
        wr && addr == `PMD_IDX_PWM |=> ##1 pwm_gen_off == $past(wdata[12:8], 2))
        else $error("pwm disables do not follow write");

    a_i2c_follows_write: assert property (@(posedge clk) disable iff (!resetn) // see [R5]
        wr && addr == `PMD_IDX_CMP_I2C |=> ##1 second_two_wire_off == $past(wdata[`PMD_BIT_I2C2], 2))
        else $error("second two-wire disable does not follow write");

    a_no_read_zero: assert property (@(posedge clk) disable iff (!resetn) // see [R3]
        !rd |=> rdata == 16'h0000)
        else $error("read data not zero without read");

    // ****************************************
    // assertions: masking and readback
    // ****************************************
    // unimplemented and unmapped positions never read back as one
    a_pwm_unimpl_zero: assert property (@(posedge clk) disable iff (!resetn) // see [R3]
        rd && addr == `PMD_IDX_PWM |=> (rdata & ~`PMD_MASK_PWM) == 16'h0000)
        else $error("unimplemented pwm register bits read nonzero");

    a_unmapped_read_zero: assert property (@(posedge clk) disable iff (!resetn) // see [R3]
        rd && addr == 2'h3 |=> rdata == 16'h0000)
        else $error("unmapped index reads nonzero");

    a_unmapped_write_ignored: assert property (@(posedge clk) disable iff (!resetn) // see [R3]
        wr && addr == 2'h3 |=> $stable(cmpI2cVal) && $stable(refclkVal) && $stable(pwmVal))
        else $error("write to unmapped index changed a register");

    a_stored_bits_masked: assert property (@(posedge clk) disable iff (!resetn) // see [R3]
        ((cmpI2cVal & ~`PMD_MASK_CMP_I2C) | (refclkVal & ~`PMD_MASK_REFCLK)
            | (pwmVal & ~`PMD_MASK_PWM)) == 16'h0000)
        else $error("unimplemented register bit holds a one");

    a_cmp_readback: assert property (@(posedge clk) disable iff (!resetn) // see [R4]
        wr && addr == `PMD_IDX_CMP_I2C ##1 rd && addr == `PMD_IDX_CMP_I2C
            |=> rdata == ($past(wdata, 2) & `PMD_MASK_CMP_I2C))
        else $error("comparator register readback mismatch");

    a_refclk_readback: assert property (@(posedge clk) disable iff (!resetn) // see [R4]
        wr && addr == `PMD_IDX_REFCLK ##1 rd && addr == `PMD_IDX_REFCLK
            |=> rdata == ($past(wdata, 2) & `PMD_MASK_REFCLK))
        else $error("refclk register readback mismatch");

    a_read_keeps_regs: assert property (@(posedge clk) disable iff (!resetn) // see [R4]
        rd |=> $stable(cmpI2cVal) && $stable(refclkVal) && $stable(pwmVal))
        else $error("read changed a register");

    // ****************************************
    // assertions: holding and reset
    // ****************************************
    // a disable level only moves two cycles after a write to its register
    a_cmp_holds_idle: assert property (@(posedge clk) disable iff (!resetn) // see [R1]
        !(wr && addr == `PMD_IDX_CMP_I2C) |=> ##1 $stable(comparator_off))
        else $error("comparator disable moved without write");

    a_i2c_holds_idle: assert property (@(posedge clk) disable iff (!resetn) // see [R5]
        !(wr && addr == `PMD_IDX_CMP_I2C) |=> ##1 $stable(second_two_wire_off))
        else $error("second two-wire disable moved without write");

    a_refclk_holds_idle: assert property (@(posedge clk) disable iff (!resetn) // see [R2]
        !(wr && addr == `PMD_IDX_REFCLK) |=> ##1 $stable(refclk_out_off))
        else $error("refclk disable moved without write");

    a_pwm_holds_idle: assert property (@(posedge clk) disable iff (!resetn) // see [R5]
        !(wr && addr == `PMD_IDX_PWM) |=> ##1 $stable(pwm_gen_off))
        else $error("pwm disables moved without write");

    a_release_all_clear: assert property (@(posedge clk) // see [R4]
        $rose(resetn) |-> rdata == 16'h0000 && comparator_off == 1'b0 && second_two_wire_off == 1'b0
            && refclk_out_off == 1'b0 && pwm_gen_off == 5'h00)
        else $error("outputs not clear after reset release");

endmodule : pmd_regs

`default_nettype wire

// file: include/pmd_defs.svh
`ifndef PMD_DEFS_SVH
`define PMD_DEFS_SVH

// ****************************************
// register indices (word offsets)
// ****************************************
`define PMD_IDX_CMP_I2C 2'h0
`define PMD_IDX_REFCLK 2'h1
`define PMD_IDX_PWM 2'h2

// ****************************************
// field positions
// ****************************************
`define PMD_BIT_CMP 10
`define PMD_BIT_I2C2 1
`define PMD_BIT_REFCLK 3
`define PMD_BIT_PWM_LO 8
`define PMD_PWM_COUNT 5

// ****************************************
// implemented bit masks and reset values
// ****************************************
`define PMD_MASK_CMP_I2C 16'h0402
`define PMD_MASK_REFCLK 16'h0008
`define PMD_MASK_PWM 16'h1f00
`define PMD_RESET_VALUE 16'h0000

`endif

// file: include/pmd_pkg.sv
`default_nettype none
package pmd_pkg;

    // ****************************************
    // types
    // ****************************************
    typedef logic [15:0] pmd_word_t;

    // software access to the register bank
    typedef struct packed {
        logic [1:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } pmd_req_t;

endpackage : pmd_pkg
`default_nettype wire

// file: tb/peripheral_module_disable_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "pmd_defs.svh"

`define CHK(got, exp) begin cmpCount++; if ((got) !== (exp)) begin errorCnt++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end

module peripheral_module_disable_regs_tb;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    logic comparatorOff;
    logic secondTwoWireOff;
    logic refclkOutOff;
    logic [4:0] pwmGenOff;
    logic [15:0] expReg [4] = '{default: 16'h0000};
    logic [15:0] expQ [$];
    logic [15:0] expV;
    logic rdQ1 = 1'b0;
    int errorCnt = 0;
    int cmpCount = 0;
    integer seed = 32'h1e4d4b75;

    pmd_regs dut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .comparator_off(comparatorOff), .second_two_wire_off(secondTwoWireOff),
        .refclk_out_off(refclkOutOff), .pwm_gen_off(pwmGenOff));

    // ****************************************
    // clock and hang guard
    // ****************************************
    initial begin
        forever #4 clk = ~clk;
    end

    initial begin
        #200000;
        errorCnt++;
        endOfTest();
    end

    // ****************************************
    // bus tasks and expected model
    // ****************************************
    function automatic logic [15:0] maskOf(input logic [1:0] a);
        case (a)
            2'h0: return `PMD_MASK_CMP_I2C;
            2'h1: return `PMD_MASK_REFCLK;
            2'h2: return `PMD_MASK_PWM;
            default: return 16'h0000; // unmapped index
        endcase
    endfunction : maskOf

    task automatic wrReg(input logic [1:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        rd <= 1'b0;
        expReg[a] = d & maskOf(a);
        @(posedge clk);
    endtask : wrReg

    task automatic rdReg(input logic [1:0] a);
        addr <= a;
        wr <= 1'b0;
        rd <= 1'b1;
        expQ.push_back(expReg[a]);
        @(posedge clk);
    endtask : rdReg

    task automatic idle(input int n);
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (n) @(posedge clk);
    endtask : idle

    // disable outputs against the model, called once writes have settled
    task automatic chkOut();
        `CHK(comparatorOff, expReg[0][10])
        `CHK(secondTwoWireOff, expReg[0][1])
        `CHK(refclkOutOff, expReg[1][3])
        `CHK(pwmGenOff, expReg[2][12:8])
    endtask : chkOut

    task automatic endOfTest();
        if (errorCnt == 0 && cmpCount > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : endOfTest

    // ****************************************
    // read data monitor: oldest note per answer
    // ****************************************
    always @(posedge clk) begin
        if (rdQ1) begin
            expV = (expQ.size() > 0) ? expQ.pop_front() : 16'hdead;
            `CHK(rdata, expV)
        end else if (resetn) begin
            `CHK(rdata, 16'h0000)
        end
        rdQ1 <= rd;
    end

    // ****************************************
    // stimulus
    // ****************************************
    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        idle(3);
        chkOut();
        for (int a = 0; a < 4; a++) rdReg(a[1:0]);
        for (int a = 0; a < 4; a++) wrReg(a[1:0], 16'hffff);
        for (int a = 0; a < 4; a++) rdReg(a[1:0]);
        idle(3);
        chkOut();
        // walking one per register, outputs after each
        for (int a = 0; a < 3; a++) begin
            for (int b = 0; b < 16; b++) begin
                wrReg(a[1:0], 16'h0001 << b);
                idle(3);
                chkOut();
                rdReg(a[1:0]);
            end
        end
        // write then read in the next cycle, every index
        for (int a = 0; a < 4; a++) begin
            wrReg(a[1:0], 16'($random(seed)));
            rdReg(a[1:0]);
        end
        // random back-to-back traffic
        repeat (80) begin
            if ($random(seed) & 1) wrReg(2'($random(seed)), 16'($random(seed)));
            else rdReg(2'($random(seed)));
        end
        idle(3);
        chkOut();
        for (int a = 0; a < 4; a++) rdReg(a[1:0]);
        // mid-run reset with every disable set, then all clear
        for (int a = 0; a < 4; a++) wrReg(a[1:0], 16'hffff);
        idle(3);
        chkOut();
        resetn <= 1'b0;
        expReg = '{default: 16'h0000};
        idle(2);
        resetn <= 1'b1;
        idle(2);
        chkOut();
        for (int a = 0; a < 4; a++) rdReg(a[1:0]);
        idle(3);
        endOfTest();
    end
endmodule : peripheral_module_disable_regs_tb

`default_nettype wire
